// >>> bench/apvg_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// Drive with encoder: takes command steps, answers with quadrature or pulses
module apvg_drive_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic line_a,
  input wire logic line_b,
  input wire logic [2:0] out_code,
  input wire logic slow,
  input wire logic cwccw,
  output logic enc_a,
  output logic enc_b
);
  logic pa, pb, act, step, sdir, pend, pdir, tga, tgb;
  logic [1:0] ph, dly;
  // Active edge per code; direction from dir line or from which line stepped
  assign act = out_code[0];
  assign step = (line_a == act && pa != act) || (out_code > 3'h3 && line_b == act && pb != act);
  assign sdir = (out_code > 3'h3) ? (line_a == act && pa != act) : (line_b ^ (out_code == 3'h2));
  // Shaft moves one quadrature phase per step, three cycles late when slow
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pa <= 1'b1;
      pb <= 1'b1;
      ph <= 2'h0;
      pend <= 1'b0;
      pdir <= 1'b0;
      dly <= 2'h0;
      tga <= 1'b0;
      tgb <= 1'b0;
    end else begin
      pa <= line_a;
      pb <= line_b;
      if (step) begin
        pend <= 1'b1;
        pdir <= sdir;
        dly <= slow ? 2'h3 : 2'h0;
      end else if (pend && dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        ph <= pdir ? ph + 2'h1 : ph - 2'h1;
        tga <= tga ^ pdir;
        tgb <= tgb ^ ~pdir;
      end
    end
  end
  // Quadrature, or a toggle on A per up step and on B per down step
  assign enc_a = cwccw ? tga : ph[0] ^ ph[1];
  assign enc_b = cwccw ? tgb : ph[1];
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import apvg_pkg::*;
  logic clock, rst, wr_en, rd_en, enc_a, enc_b, cmd_line_a, cmd_line_b, slow, mon_en, cur_pol;
  logic pa, pb, pea, peb, ia, ib;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, d, v, m;
  logic [2:0] cur_code;
  logic [1:0] cur_ipt;
  int mismatches, checks_done, cnt_a, cnt_b, fb, wid, seed, b_a, b_b, b_f, i, c, n, da, db;

  apvg_top u_dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .enc_a(enc_a), .enc_b(enc_b), .cmd_line_a(cmd_line_a), .cmd_line_b(cmd_line_b));
  apvg_drive_model u_drive (.clock(clock), .rst(rst), .line_a(cmd_line_a), .line_b(cmd_line_b),
    .out_code(cur_code), .slow(slow), .cwccw(cur_ipt == 2'h3), .enc_a(enc_a), .enc_b(enc_b));

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] val);
    @(posedge clock);
    addr <= a;
    wr_data <= val;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task waitfor(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] val);
    for (int k = 0; k < 3000; k++) begin
      rd(a);
      if ((d & mk) === val) return;
    end
    chk("wait_limit", d & mk, val);
    summarize();
  endtask
  task go(input logic [31:0] s, input logic [31:0] t, input logic [31:0] r, input logic [31:0] cm);
    wr(ADDR_START, s);
    wr(ADDR_TARGET, t);
    wr(ADDR_RAMP_US, r);
    wr(ADDR_CMD, cm);
  endtask

  // Reference counts of command steps, pulse widths and decoded feedback
  always @(posedge clock) begin
    ia = enc_a ^ cur_pol;
    ib = enc_b ^ cur_pol;
    if (mon_en) begin
      if (cmd_line_a === cur_code[0] && pa !== cur_code[0]) cnt_a++;
      if (cmd_line_b === cur_code[0] && pb !== cur_code[0]) cnt_b++;
      case (cur_ipt)
        2'h0: fb += int'(ia && !pea && !ib);
        2'h1: fb += int'(ia != pea);
        2'h2: fb += int'(ia != pea) + int'(ib != peb);
        default: fb += int'(ia && !pea) - int'(ib && !peb);
      endcase
      if (cmd_line_a === cur_code[0]) wid++;
      else if (wid != 0) begin
        chk("pulse_width", wid, 32'(PULSE_CYC));
        wid = 0;
      end
    end else wid = 0;
    pa = cmd_line_a;
    pb = cmd_line_b;
    pea = ia;
    peb = ib;
  end

  // Timeout
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 48798;
    {rst, wr_en, rd_en, addr, wr_data, cur_code, cur_ipt, cur_pol, slow, mon_en} = '0;
    rst = 1'b1;
    {mismatches, checks_done, cnt_a, cnt_b, fb, wid} = '0;
    {pa, pb, pea, peb} = 4'hC;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    #1 chk("idle_a", cmd_line_a, 32'h0000_0001);
    rd(ADDR_CFG);
    chk("cfg_reset", d, 32'h0000_0000);
    wr(8'h30, $random(seed));
    rd(8'h30);
    chk("unmapped", d, 32'h0000_0000);
    for (i = 0; i < 6; i++) begin
      m = (i == 1) ? 32'h807F_FFFF : (i == 2) ? 32'hFFFF_FFFF : 32'h007F_FFFF;
      rd(ADDR_START + 8'(4 * i));
      chk("reg_reset", d, WORD_RST);
      v = $random(seed);
      wr(ADDR_START + 8'(4 * i), v);
      rd(ADDR_START + 8'(4 * i));
      chk("reg_value", d, v & m);
    end
    wr(ADDR_CFG, 32'h0000_0001);
    wr(ADDR_CFG, 32'h0000_0016);
    rd(ADDR_CFG);
    chk("cfg_bad_code", d, 32'h0000_0011);
    v = $random(seed);
    wr(ADDR_POS, v);
    rd(ADDR_POS);
    chk("pos_rw", d, v & 32'h0FFF_FFFF);
    for (c = 0; c < 6; c++) for (n = 0; n < 2; n++) begin
      cur_code = 3'(c);
      wr(ADDR_CFG, 32'h0000_0080 | 32'(c));
      repeat (3) @(posedge clock);
      chk("idle_level", cmd_line_a, 32'(!cur_code[0]));
      wr(ADDR_POS, 32'h0000_0000);
      b_a = cnt_a;
      b_b = cnt_b;
      mon_en = 1'b1;
      go(32'h000F_4240, n ? 32'h800F_4240 : 32'h000F_4240, 32'h0000_0000, 32'h0000_0001);
      repeat (300) @(posedge clock);
      if (c < 4) chk("dir_level", cmd_line_b, 32'((c == 2) ^ !n));
      rd(ADDR_STATUS);
      chk("run_status", d & 32'h0000_000B, 32'h0000_0001 | 32'(n << 3));
      repeat ($unsigned($random(seed)) % 100) @(posedge clock);
      wr(ADDR_CMD, 32'h0000_0010);
      rd(ADDR_RATE);
      chk("emg_rate", d, 32'h0000_0000);
      repeat (20) @(posedge clock);
      mon_en = 1'b0;
      da = cnt_a - b_a;
      db = cnt_b - b_b;
      rd(ADDR_POS);
      chk("cmd_position", d, 32'(c < 4 ? (n ? -da : da) : da - db) & 32'h0FFF_FFFF);
      chk("steps_seen", 32'((c > 3 && n ? db : da) >= 2), 32'h0000_0001);
      chk("wrong_line", 32'(c > 3 ? (n ? da : db) : 0), 32'h0000_0000);
    end
    cur_code = 3'h0;
    for (i = 0; i < 8; i++) begin
      cur_ipt = 2'(i);
      cur_pol = i[2];
      slow = i[0];
      wr(ADDR_CFG, {25'h000_0000, i[2], cur_ipt, 4'h0});
      repeat (6) @(posedge clock);
      wr(ADDR_POS, 32'h0000_0000);
      b_f = fb;
      mon_en = 1'b1;
      go(32'h000F_4240, 32'h000F_4240, 32'h0000_0000, 32'h0000_0001);
      repeat (500) @(posedge clock);
      wr(ADDR_CMD, 32'h0000_0010);
      repeat (20) @(posedge clock);
      mon_en = 1'b0;
      rd(ADDR_POS);
      chk("fb_position", d, 32'(fb - b_f) & 32'h0FFF_FFFF);
    end
    wr(ADDR_CFG, 32'h0000_0080);
    go(32'h0000_03E8, 32'h0000_044C, 32'h0000_000A, 32'h0000_0001);
    rd(ADDR_RATE);
    chk("ramp_begin", 32'(d >= 32'h0000_03E8 && d <= 32'h0000_03F2), 32'h0000_0001);
    waitfor(ADDR_RATE, 32'hFFFF_FFFF, 32'h0000_044C);
    wr(ADDR_REVISED, 32'h0000_07D0);
    wr(ADDR_CMD, 32'h0000_0004);
    repeat (100) @(posedge clock);
    rd(ADDR_RATE);
    chk("change_unfixed", d, 32'h0000_044C);
    wr(ADDR_RANGE, 32'h0000_041A);
    wr(ADDR_CMD, 32'h0000_0020);
    wr(ADDR_CMD, 32'h0000_0004);
    waitfor(ADDR_RATE, 32'hFFFF_FFFF, 32'h0000_041A);
    wr(ADDR_CMD, 32'h0000_0040);
    rd(ADDR_STATUS);
    chk("unfixed", d & 32'h0000_0020, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0008);
    rd(ADDR_STATUS);
    chk("halting", d & 32'h0000_0003, 32'h0000_0002);
    waitfor(ADDR_STATUS, 32'h0000_0003, 32'h0000_0000);
    wr(ADDR_BLEND, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0002);
    rd(ADDR_STATUS);
    chk("scurve_run", d & 32'h0000_0017, 32'h0000_0015);
    waitfor(ADDR_RATE, 32'hFFFF_FFFF, 32'h0000_044C);
    wr(ADDR_CMD, 32'h0000_0008);
    waitfor(ADDR_STATUS, 32'h0000_0003, 32'h0000_0000);
    go(32'h007F_FFFF, 32'h007F_FFFF, 32'h0000_0000, 32'h0000_0001);
    rd(ADDR_RATE);
    chk("rate_max", d, 32'(RATE_MAX));
    wr(ADDR_CMD, 32'h0000_0010);
    summarize();
  end
endmodule
`default_nettype wire

// >>> verilog/apvg_pkg.sv
`default_nettype none
package apvg_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int PULSE_TIME_NS = 50;
  // Least pulse width, rounded up to whole cycles
  localparam logic [2:0] PULSE_CYC = 3'((PULSE_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [27:0] CLK_HZ = 28'h5F5_E100;
  localparam logic [39:0] US_CYCLES = 40'(CLK_MHZ);

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int RATE_W = 23;
  localparam int POS_W = 28;
  localparam logic [22:0] RATE_MAX = 23'h63_FF9C;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_START = 8'h04;
  localparam logic [7:0] ADDR_TARGET = 8'h08;
  localparam logic [7:0] ADDR_RAMP_US = 8'h0C;
  localparam logic [7:0] ADDR_BLEND = 8'h10;
  localparam logic [7:0] ADDR_REVISED = 8'h14;
  localparam logic [7:0] ADDR_RANGE = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_RATE = 8'h24;
  localparam logic [7:0] ADDR_POS = 8'h28;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_OUT_LSB = 0;
  localparam int CFG_IPT_LSB = 4;
  localparam int CFG_LOGIC_BIT = 6;
  localparam int CFG_SRC_BIT = 7;
  localparam int TARGET_NEG_BIT = 31;
  localparam int CMD_TRAP = 0;
  localparam int CMD_SCURVE = 1;
  localparam int CMD_CHANGE = 2;
  localparam int CMD_HALT = 3;
  localparam int CMD_EMG = 4;
  localparam int CMD_FIX = 5;
  localparam int CMD_UNFIX = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] OUT_PD_FALL_HI = 3'h0;
  localparam logic [2:0] OUT_PD_RISE_HI = 3'h1;
  localparam logic [2:0] OUT_PD_FALL_LO = 3'h2;
  localparam logic [2:0] OUT_PD_RISE_HI2 = 3'h3;
  localparam logic [2:0] OUT_CW_FALL = 3'h4;
  localparam logic [2:0] OUT_CW_RISE = 3'h5;
  localparam logic [1:0] IPT_1X = 2'h0;
  localparam logic [1:0] IPT_2X = 2'h1;
  localparam logic [1:0] IPT_4X = 2'h2;
  localparam logic [1:0] IPT_CWCCW = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } apvg_state_t;
endpackage
`default_nettype wire

// >>> verilog/apvg_top.sv
`timescale 1ns/1ns
`default_nettype none
//Contract
// - Six selectable command pulse encodings
// - Codes 0,1: fall/rise step, dir high positive
// - Code 2 dir low positive; code 3 high
// - Codes 4,5: separate CW/CCW lines
// - Four feedback types: 1X, 2X, 4X, CW/CCW
// - Feedback polarity: normally low or high
// - Feedback type matters only with external source
// - 28-bit up/down position counter
// - Source code 0 feedback, 1 command
// - Trapezoid start ramps, holds; sign sets direction
// - S-curve start ramps, then holds rate
// - S shaping within blend span; zero pure
// - Trapezoid ramp spans programmed time, S-curve ramp longer; rates in pps
// - Speed change ramps with running profile, taken only while range fixed
// - Unfix removes the speed range limit
// - Controlled halt decelerates with running profile
// - Emergency stop halts new pulses at once; a pulse under way runs to its end
// - Current rate readable, 0 to 6553500, or 0 to range_max for commands taken while range fixed
module apvg_top
  import apvg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic cmd_line_a,
  output logic cmd_line_b
);
  import apvg_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [22:0] absdiff(input logic [22:0] a, input logic [22:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [22:0] lim(input logic [22:0] r, input logic fixed, input logic [22:0] top);
    logic [22:0] m;
    m = fixed ? top : RATE_MAX;
    return (r > m) ? m : r;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] cfg_out_mode;
  logic [1:0] cfg_ipt;
  logic cfg_logic;
  logic cfg_src;
  logic [22:0] start_rate;
  logic [22:0] target_rate;
  logic target_neg;
  logic [31:0] ramp_us;
  logic [22:0] blend_span;
  logic [22:0] revised_rate;
  logic [22:0] range_max;
  logic range_fixed;
  logic [27:0] position;
  logic [6:0] cmd;
  logic pos_wr;

  assign cmd = (wr_en && addr == ADDR_CMD) ? wr_data[6:0] : 7'h00;
  assign pos_wr = wr_en && addr == ADDR_POS;

  // Configuration; an output code above five is refused
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_out_mode <= CFG_RST[2:0];
      cfg_ipt <= CFG_RST[5:4];
      cfg_logic <= CFG_RST[CFG_LOGIC_BIT];
      cfg_src <= CFG_RST[CFG_SRC_BIT];
    end else if (wr_en && addr == ADDR_CFG) begin
      if (wr_data[CFG_OUT_LSB +: 3] <= OUT_CW_RISE) begin
        cfg_out_mode <= wr_data[CFG_OUT_LSB +: 3];
      end
      cfg_ipt <= wr_data[CFG_IPT_LSB +: 2];
      cfg_logic <= wr_data[CFG_LOGIC_BIT];
      cfg_src <= wr_data[CFG_SRC_BIT];
    end
  end

  // Motion parameters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_rate <= WORD_RST[22:0];
      target_rate <= WORD_RST[22:0];
      target_neg <= WORD_RST[0];
      ramp_us <= WORD_RST;
      blend_span <= WORD_RST[22:0];
      revised_rate <= WORD_RST[22:0];
      range_max <= WORD_RST[22:0];
    end else if (wr_en) begin
      unique case (addr)
        ADDR_START: start_rate <= wr_data[22:0];
        ADDR_TARGET: begin
          target_rate <= wr_data[22:0];
          target_neg <= wr_data[TARGET_NEG_BIT];
        end
        ADDR_RAMP_US: ramp_us <= wr_data;
        ADDR_BLEND: blend_span <= wr_data[22:0];
        ADDR_REVISED: revised_rate <= wr_data[22:0];
        ADDR_RANGE: range_max <= wr_data[22:0];
        default: ;
      endcase
    end
  end

  // Speed range pin and release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      range_fixed <= 1'b0;
    end else if (cmd[CMD_FIX]) begin
      range_fixed <= 1'b1;
    end else if (cmd[CMD_UNFIX]) begin
      range_fixed <= 1'b0;
    end
  end

  // ****************************************
  // Feedback decoder
  // ****************************************
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  logic a_q;
  logic b_q;
  logic a_lvl, b_lvl, a_prv, b_prv;
  logic a_rise, a_fall, b_rise, b_fall;
  logic fb_up;
  logic fb_dn;

  // Two-stage synchronisers, then one stage of history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_sync <= {a_sync[0], enc_a};
      b_sync <= {b_sync[0], enc_b};
      a_q <= a_sync[1];
      b_q <= b_sync[1];
    end
  end

  // Normally-high lines are inverted so the active edge is a rise
  assign a_lvl = a_sync[1] ^ cfg_logic;
  assign b_lvl = b_sync[1] ^ cfg_logic;
  assign a_prv = a_q ^ cfg_logic;
  assign b_prv = b_q ^ cfg_logic;
  assign a_rise = a_lvl & ~a_prv;
  assign a_fall = ~a_lvl & a_prv;
  assign b_rise = b_lvl & ~b_prv;
  assign b_fall = ~b_lvl & b_prv;

  // Count direction per input type; A leading B counts up
  always_comb begin
    fb_up = 1'b0;
    fb_dn = 1'b0;
    unique case (cfg_ipt)
      IPT_1X: begin
        fb_up = a_rise & ~b_lvl;
        fb_dn = a_fall & ~b_lvl;
      end
      IPT_2X: begin
        fb_up = (a_rise & ~b_lvl) | (a_fall & b_lvl);
        fb_dn = (a_fall & ~b_lvl) | (a_rise & b_lvl);
      end
      IPT_4X: begin
        fb_up = (a_rise & ~b_lvl) | (a_fall & b_lvl) | (b_rise & a_lvl) | (b_fall & ~a_lvl);
        fb_dn = (a_fall & ~b_lvl) | (a_rise & b_lvl) | (b_fall & a_lvl) | (b_rise & ~a_lvl);
      end
      IPT_CWCCW: begin
        fb_up = a_rise;
        fb_dn = b_rise;
      end
    endcase
  end

  // ****************************************
  // Rate profile engine
  // ****************************************
  apvg_state_t st;
  logic scurve;
  logic dir_neg;
  logic [22:0] cur_rate;
  logic [22:0] goal;
  logic [22:0] from;
  logic [39:0] err;
  logic [39:0] t_cyc;
  logic [22:0] delta;
  logic [22:0] span_eff;
  logic in_blend;
  logic [22:0] eff;
  logic [39:0] err_sum;

  // Bresenham spread of the rate delta over the ramp time
  assign t_cyc = {8'h00, ramp_us} * US_CYCLES;
  assign delta = absdiff(goal, from);
  assign span_eff = (blend_span == 23'h00_0000) ? (delta >> 1) : blend_span;
  assign in_blend = absdiff(cur_rate, from) < span_eff || absdiff(goal, cur_rate) < span_eff;
  // Halved slope near both ends softens the jerk
  assign eff = (scurve && in_blend) ? ((delta >> 1) | 23'h00_0001) : (delta | 23'h00_0001);
  assign err_sum = err + {17'h0_0000, eff};

  // Commands, by priority: emergency, halt, change, start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= ST_IDLE;
      scurve <= 1'b0;
      dir_neg <= 1'b0;
      cur_rate <= 23'h00_0000;
      goal <= 23'h00_0000;
      from <= 23'h00_0000;
      err <= 40'h00_0000_0000;
    end else if (cmd[CMD_EMG]) begin
      st <= ST_IDLE;
      cur_rate <= 23'h00_0000;
      goal <= 23'h00_0000;
      err <= 40'h00_0000_0000;
    end else if (cmd[CMD_HALT] && st != ST_IDLE) begin
      st <= ST_HALT;
      goal <= 23'h00_0000;
      from <= cur_rate;
      err <= 40'h00_0000_0000;
    end else if (cmd[CMD_CHANGE] && st == ST_RUN && range_fixed) begin
      goal <= lim(revised_rate, range_fixed, range_max);
      from <= cur_rate;
      err <= 40'h00_0000_0000;
    end else if ((cmd[CMD_TRAP] || cmd[CMD_SCURVE]) && st == ST_IDLE) begin
      st <= ST_RUN;
      scurve <= ~cmd[CMD_TRAP];
      dir_neg <= target_neg;
      cur_rate <= lim(start_rate, range_fixed, range_max);
      goal <= lim(target_rate, range_fixed, range_max);
      from <= lim(start_rate, range_fixed, range_max);
      err <= 40'h00_0000_0000;
    end else if (st == ST_HALT && cur_rate == 23'h00_0000) begin
      st <= ST_IDLE;
    end else if (cur_rate != goal) begin
      if (t_cyc == 40'h00_0000_0000) begin
        cur_rate <= goal;
      end else if (err_sum >= t_cyc) begin
        cur_rate <= (goal > cur_rate) ? cur_rate + 23'h00_0001 : cur_rate - 23'h00_0001;
        err <= err_sum - t_cyc;
      end else begin
        err <= err_sum;
      end
    end
  end

  // ****************************************
  // Pulse generator
  // ****************************************
  logic [26:0] phase;
  logic [27:0] ph_sum;
  logic fire;
  logic step_go;
  logic [2:0] pulse_cnt;

  assign ph_sum = {1'b0, phase} + {5'h00, cur_rate};
  assign fire = st != ST_IDLE && ph_sum >= CLK_HZ;
  assign step_go = fire && pulse_cnt == 3'h0;

  // Phase accumulator wraps once per commanded step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 27'h000_0000;
    end else if (st == ST_IDLE) begin
      phase <= 27'h000_0000;
    end else begin
      phase <= fire ? 27'(ph_sum - CLK_HZ) : ph_sum[26:0];
    end
  end

  // Pulse timer keeps running after a stop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_cnt <= 3'h0;
    end else if (step_go) begin
      pulse_cnt <= PULSE_CYC;
    end else if (pulse_cnt != 3'h0) begin
      pulse_cnt <= pulse_cnt - 3'h1;
    end
  end

  // Line encoding per output code
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_line_a <= 1'b1;
      cmd_line_b <= 1'b1;
    end else begin
      unique case (cfg_out_mode)
        OUT_PD_FALL_HI: begin
          cmd_line_a <= pulse_cnt == 3'h0;
          cmd_line_b <= ~dir_neg;
        end
        OUT_PD_RISE_HI: begin
          cmd_line_a <= pulse_cnt != 3'h0;
          cmd_line_b <= ~dir_neg;
        end
        OUT_PD_FALL_LO: begin
          cmd_line_a <= pulse_cnt == 3'h0;
          cmd_line_b <= dir_neg;
        end
        OUT_PD_RISE_HI2: begin
          cmd_line_a <= pulse_cnt != 3'h0;
          cmd_line_b <= ~dir_neg;
        end
        OUT_CW_FALL: begin
          cmd_line_a <= ~(pulse_cnt != 3'h0 && !dir_neg);
          cmd_line_b <= ~(pulse_cnt != 3'h0 && dir_neg);
        end
        OUT_CW_RISE: begin
          cmd_line_a <= pulse_cnt != 3'h0 && !dir_neg;
          cmd_line_b <= pulse_cnt != 3'h0 && dir_neg;
        end
        default: begin
          cmd_line_a <= 1'b1;
          cmd_line_b <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Position counter
  // ****************************************
  // Software write wins over a count in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      position <= 28'h000_0000;
    end else if (pos_wr) begin
      position <= wr_data[27:0];
    end else if (cfg_src) begin
      if (step_go) begin
        position <= dir_neg ? position - 28'h000_0001 : position + 28'h000_0001;
      end
    end else if (fb_up && !fb_dn) begin
      position <= position + 28'h000_0001;
    end else if (fb_dn && !fb_up) begin
      position <= position - 28'h000_0001;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [31:0] next_rd_data;

  always_comb begin
    next_rd_data = 32'h0000_0000;
    unique case (addr)
      ADDR_CFG: next_rd_data = {24'h00_0000, cfg_src, cfg_logic, cfg_ipt, 1'b0, cfg_out_mode};
      ADDR_START: next_rd_data = {9'h000, start_rate};
      ADDR_TARGET: next_rd_data = {target_neg, 8'h00, target_rate};
      ADDR_RAMP_US: next_rd_data = ramp_us;
      ADDR_BLEND: next_rd_data = {9'h000, blend_span};
      ADDR_REVISED: next_rd_data = {9'h000, revised_rate};
      ADDR_RANGE: next_rd_data = {9'h000, range_max};
      ADDR_STATUS: next_rd_data = {26'h000_0000, range_fixed, scurve, dir_neg, cur_rate != goal, st};
      ADDR_RATE: next_rd_data = {9'h000, cur_rate};
      ADDR_POS: next_rd_data = {4'h0, position};
      default: next_rd_data = 32'h0000_0000;
    endcase
  end

  // Read data stand for one cycle only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_en ? next_rd_data : 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_EMG_HALT: assert property (@(posedge clock) disable iff (rst)
    cmd[CMD_EMG] |=> (cur_rate == 23'h00_0000 && st == ST_IDLE && !fire))
    else $error("emergency stop did not halt output");
  AST_PULSE_FINISH: assert property (@(posedge clock) disable iff (rst)
    (pulse_cnt != 3'h0) |=> (pulse_cnt == $past(pulse_cnt) - 3'h1))
    else $error("pulse cut short");
  AST_IDLE_LEVEL: assert property (@(posedge clock) disable iff (rst)
    (cfg_out_mode == OUT_PD_FALL_HI && pulse_cnt == 3'h0 && !(wr_en && addr == ADDR_CFG))
      |=> cmd_line_a && cmd_line_b == !$past(dir_neg))
    else $error("falling mode idle level wrong");
  AST_DIR_LOW: assert property (@(posedge clock) disable iff (rst)
    (cfg_out_mode == OUT_PD_FALL_LO && !(wr_en && addr == ADDR_CFG)) |=> (cmd_line_b == $past(dir_neg)))
    else $error("code 2 direction polarity wrong");
  AST_CW_LINE: assert property (@(posedge clock) disable iff (rst)
    (cfg_out_mode == OUT_CW_RISE && pulse_cnt != 3'h0 && !(wr_en && addr == ADDR_CFG))
      |=> (cmd_line_a == !$past(dir_neg) && cmd_line_b == $past(dir_neg)))
    else $error("CW/CCW line selection wrong");
  AST_CMD_COUNT: assert property (@(posedge clock) disable iff (rst)
    (cfg_src && step_go && !dir_neg && !pos_wr) |=> (position == $past(position) + 28'h000_0001))
    else $error("command pulse not counted");
  AST_FB_COUNT: assert property (@(posedge clock) disable iff (rst)
    (!cfg_src && fb_up && !fb_dn && !pos_wr) |=> (position == $past(position) + 28'h000_0001))
    else $error("feedback pulse not counted");
  AST_RATE_RANGE: assert property (@(posedge clock) disable iff (rst)
    cur_rate <= RATE_MAX)
    else $error("rate above range");
  AST_RAMP_STEP: assert property (@(posedge clock) disable iff (rst)
    (st == ST_RUN && cmd == 7'h00 && t_cyc != 40'h00_0000_0000) |=>
      (cur_rate == $past(cur_rate) || cur_rate == $past(cur_rate) + 23'h00_0001
       || cur_rate + 23'h00_0001 == $past(cur_rate)))
    else $error("ramp jumped");
  AST_START: assert property (@(posedge clock) disable iff (rst)
    (cmd[CMD_SCURVE] && !cmd[CMD_TRAP] && !cmd[CMD_EMG] && st == ST_IDLE)
      |=> (st == ST_RUN && scurve && dir_neg == $past(target_neg)))
    else $error("start not taken");
  AST_HALT_GOAL: assert property (@(posedge clock) disable iff (rst)
    (st == ST_HALT) |-> (goal == 23'h00_0000))
    else $error("halt not ramping to zero");
  COV_AT_SPEED: cover property (@(posedge clock) disable iff (rst)
    st == ST_RUN && cur_rate == goal && goal != 23'h00_0000);
  COV_HALT_DONE: cover property (@(posedge clock) disable iff (rst)
    st == ST_HALT ##1 st == ST_IDLE);
  COV_EMG_PULSE: cover property (@(posedge clock) disable iff (rst)
    cmd[CMD_EMG] && pulse_cnt != 3'h0);
endmodule
`default_nettype wire
